// >>> rtl/pifc_defines.vh
`ifndef PIFC_DEFINES_VH
`define PIFC_DEFINES_VH

// ****************************************************************
// Register offsets.
// ****************************************************************
`define PIFC_OFS_POWER   8'h2D
`define PIFC_OFS_ENABLE  8'h2E
`define PIFC_OFS_ROUTE   8'h2F
`define PIFC_OFS_FLAGS   8'h30
`define PIFC_OFS_FORMAT  8'h31
`define PIFC_OFS_DATA_LO 8'h32
`define PIFC_OFS_DATA_HI 8'h37

// ****************************************************************
// Reset values; power-up lands in standby.
// ****************************************************************
`define PIFC_RST_POWER   8'h00
`define PIFC_RST_ENABLE  8'h00
`define PIFC_RST_ROUTE   8'h00
`define PIFC_RST_FORMAT  8'h00

// ****************************************************************
// Field positions of the power mode control register.
// ****************************************************************
`define PIFC_PWR_CHAIN   5
`define PIFC_PWR_AUTO    4
`define PIFC_PWR_MEAS    3
`define PIFC_PWR_SLEEP   2
`define PIFC_PWR_RATE_HI 1
`define PIFC_PWR_RATE_LO 0

// ****************************************************************
// Bit positions shared by enable, routing and flag registers.
// ****************************************************************
`define PIFC_EV_DRDY     7
`define PIFC_EV_TAP1     6
`define PIFC_EV_TAP2     5
`define PIFC_EV_ACT      4
`define PIFC_EV_INACT    3
`define PIFC_EV_FALL     2
`define PIFC_EV_WMARK    1
`define PIFC_EV_OVRUN    0
`define PIFC_DATA_CLR    8'h83

// ****************************************************************
// Field positions of the output format control register.
// ****************************************************************
`define PIFC_FMT_STEST   7
`define PIFC_FMT_SPI3    6
`define PIFC_FMT_INV     5
`define PIFC_FMT_FULL    3
`define PIFC_FMT_JUST    2
`define PIFC_FMT_RNG_HI  1
`define PIFC_FMT_RNG_LO  0
`define PIFC_FMT_MASK    8'hEF

// ****************************************************************
// Timing: fastest sleep reading rate and the clock rate.
// ****************************************************************
`define PIFC_CLK_HZ      50000000
`define PIFC_SLEEP_HZ    8
`define PIFC_SLEEP_CYC   (`PIFC_CLK_HZ / `PIFC_SLEEP_HZ)

`endif

// >>> rtl/pifc_regs.v
`timescale 1ns/1ps
`default_nettype none
`include "pifc_defines.vh"

// Contract
// R01: Chaining alternates inactivity then activity detection.
// R02: Chain plus auto-sleep: sleep on inactivity, wake.
// R03: Auto-sleep ignored while chaining is clear.
// R04: Host goes via standby when clearing mode bits.
// R05: Measure bit selects standby or measurement; reset standby.
// R06: Sleep suppresses data-ready, FIFO writes; slow rate.
// R07: Sleep runs only activity; data keeps updating.
// R08: Sleep rate field gives 8, 4, 2, 1 Hz.
// R09: Enable bit gates each source to pins.
// R10: Data-ready, watermark, overrun always run.
// R11: Host configures sources before enabling them.
// R12: Routing bit zero pin A, one pin B.
// R13: Each pin ORs its enabled routed sources.
// R14: Data flags set always, cleared by data reads.
// R15: Other flags cleared by reading flag register.
// R16: Self-test bit applies force to sensor.
// R17: Serial bit selects three- or four-wire port.
// R18: Polarity bit: zero active high, one low.
// R19: Full resolution keeps 4 mg per LSB.
// R20: Justify bit: left or sign-extended right.
// R21: Range field selects 2, 4, 8, 16 g.
// R22: Clip output except at 16 g range.
module pifc_regs #(
   parameter P_SLEEP_CYC = `PIFC_SLEEP_CYC,
   parameter P_RAW_W     = 13
) (
   input  wire                 i_clk,
   input  wire                 i_nrst,
   input  wire [7:0]           i_addr,
   input  wire [7:0]           i_wdata,
   input  wire                 i_wr,
   input  wire                 i_rd,
   output reg  [7:0]           o_rdata,
   input  wire                 i_odr_clk,
   input  wire                 i_act_on,
   input  wire                 i_inact_on,
   input  wire [7:0]           i_evt,
   input  wire [3*P_RAW_W-1:0] i_raw,
   output reg  [47:0]          o_data,
   output reg                  o_irq_pin_a,
   output reg                  o_irq_pin_b,
   output reg                  o_measure,
   output reg                  o_asleep,
   output reg                  o_sample_tick,
   output reg                  o_fifo_wr_en,
   output reg                  o_act_run,
   output reg                  o_inact_run,
   output reg                  o_other_run,
   output reg                  o_self_test,
   output reg                  o_spi3
);

   // ****************************************************************
   // Chaining phase, one-hot.
   // ****************************************************************
   localparam [1:0] S_WAIT_INACT = 2'b01;
   localparam [1:0] S_WAIT_ACT   = 2'b10;

   reg  [7:0]  power_mode_control_ff;
   reg  [7:0]  interrupt_enable_mask_ff;
   reg  [7:0]  interrupt_pin_routing_ff;
   reg  [7:0]  interrupt_event_flags_ff;
   reg  [7:0]  output_format_control_ff;
   reg  [7:0]  nxt_flags;
   reg  [7:0]  nxt_rdata;
   reg  [1:0]  phase_ff;
   reg  [1:0]  nxt_phase;
   reg         auto_sleep_ff;
   reg         nxt_auto_sleep;
   reg  [2:0]  odr_sync_ff;
   reg  [31:0] sleep_cnt_ff;
   reg  [31:0] nxt_sleep_cnt;
   reg         nxt_tick;
   reg  [7:0]  evt_gated;
   reg  [7:0]  live;

   wire chain   = power_mode_control_ff[`PIFC_PWR_CHAIN];
   wire autoslp = power_mode_control_ff[`PIFC_PWR_AUTO];
   wire meas    = power_mode_control_ff[`PIFC_PWR_MEAS];
   wire [1:0] rate = power_mode_control_ff[`PIFC_PWR_RATE_HI:
                                           `PIFC_PWR_RATE_LO];
   wire inv     = output_format_control_ff[`PIFC_FMT_INV];
   wire full    = output_format_control_ff[`PIFC_FMT_FULL];
   wire just    = output_format_control_ff[`PIFC_FMT_JUST];
   wire [1:0] rng = output_format_control_ff[`PIFC_FMT_RNG_HI:
                                             `PIFC_FMT_RNG_LO];

   // The detector phase only follows chaining when both detectors are switched on.
   wire chain_on = chain & i_act_on & i_inact_on;
   // Auto-sleep has no effect unless chaining is set.
   wire auto_ok  = chain & autoslp; // [R03]
   wire sleeping = power_mode_control_ff[`PIFC_PWR_SLEEP] |
                   auto_sleep_ff; // [R02]

   wire wr_hit   = i_wr;
   wire rd_flags = i_rd & (i_addr == `PIFC_OFS_FLAGS);
   wire rd_data  = i_rd & (i_addr >= `PIFC_OFS_DATA_LO) &
                   (i_addr <= `PIFC_OFS_DATA_HI);
   wire odr_edge = odr_sync_ff[1] & ~odr_sync_ff[2];

   // ****************************************************************
   // Output formatting of one axis.
   // ****************************************************************
   // The raw sample is 13-bit at 4 mg per count, so one g range step
   // doubles the count limit. Clipping happens before scaling so the
   // narrow modes never wrap around.
   function [15:0] fmt;
      input [P_RAW_W-1:0] raw;
      input [1:0]         r;
      input               fr;
      input               lj;
      reg signed [15:0] v;
      reg signed [15:0] lim;
      reg [4:0]         w;
      begin
         v   = {{(16-P_RAW_W){raw[P_RAW_W-1]}}, raw};
         lim = 16'sh0200 <<< r; // [R21]
         // Every range but the widest is clipped at its limits.
         if (r != 2'b11) begin // [R22]
            if (v > lim - 16'sh0001)
               v = lim - 16'sh0001;
            else if (v < -lim)
               v = -lim;
         end
         // Full resolution keeps 4 mg per count; else 10 bits wide.
         if (fr) begin // [R19]
            w = 5'h0A + {3'h0, r};
         end else begin
            v = v >>> r;
            w = 5'h0A;
         end
         // Left justify pushes the MSB up to bit 15.
         if (lj) // [R20]
            fmt = v << (5'h10 - w);
         else
            fmt = v;
      end
   endfunction

   // ****************************************************************
   // Register writes.
   // ****************************************************************
   // Writes to unmapped offsets are dropped without effect.
   always @(posedge i_clk) begin
      if (!i_nrst) begin
         power_mode_control_ff    <= `PIFC_RST_POWER; // [R05]
         interrupt_enable_mask_ff <= `PIFC_RST_ENABLE;
         interrupt_pin_routing_ff <= `PIFC_RST_ROUTE;
         output_format_control_ff <= `PIFC_RST_FORMAT;
      end else if (wr_hit) begin
         case (i_addr)
            `PIFC_OFS_POWER:
               power_mode_control_ff <= i_wdata & 8'h3F;
            `PIFC_OFS_ENABLE:
               interrupt_enable_mask_ff <= i_wdata;
            `PIFC_OFS_ROUTE:
               interrupt_pin_routing_ff <= i_wdata;
            `PIFC_OFS_FORMAT:
               output_format_control_ff <= i_wdata & `PIFC_FMT_MASK;
            default: begin
            end
         endcase
      end
   end

   // ****************************************************************
   // Read mux.
   // ****************************************************************
   // The flag register shows its value before the read clears it.
   always @* begin
      nxt_rdata = 8'h00;
      if (i_rd) begin
         case (i_addr)
            `PIFC_OFS_POWER:  nxt_rdata = power_mode_control_ff;
            `PIFC_OFS_ENABLE: nxt_rdata = interrupt_enable_mask_ff;
            `PIFC_OFS_ROUTE:  nxt_rdata = interrupt_pin_routing_ff;
            `PIFC_OFS_FLAGS:  nxt_rdata = interrupt_event_flags_ff;
            `PIFC_OFS_FORMAT: nxt_rdata = output_format_control_ff;
            default:          nxt_rdata = 8'h00;
         endcase
      end
   end

   always @(posedge i_clk) begin
      if (!i_nrst)
         o_rdata <= 8'h00;
      else
         o_rdata <= nxt_rdata;
   end

   // ****************************************************************
   // Event flags.
   // ****************************************************************
   // Data-ready is held off while asleep; the watermark and overrun
   // functions keep running whatever the enable mask says.
   always @* begin
      evt_gated = i_evt; // [R10]
      if (sleeping)
         evt_gated[`PIFC_EV_DRDY] = 1'b0; // [R06]
      if (!meas)
         evt_gated = 8'h00;
   end

   // Clear first, then set, so an event in the clearing cycle wins.
   always @* begin
      nxt_flags = interrupt_event_flags_ff;
      if (rd_data)
         nxt_flags = nxt_flags & ~`PIFC_DATA_CLR; // [R14]
      if (rd_flags)
         nxt_flags = nxt_flags & `PIFC_DATA_CLR; // [R15]
      nxt_flags = nxt_flags | evt_gated; // [R14]
   end

   always @(posedge i_clk) begin
      if (!i_nrst)
         interrupt_event_flags_ff <= 8'h00;
      else
         interrupt_event_flags_ff <= nxt_flags;
   end

   // ****************************************************************
   // Interrupt pins.
   // ****************************************************************
   always @* begin
      live = interrupt_event_flags_ff & interrupt_enable_mask_ff; // [R09]
   end

   // Polarity inverts both pins; idle level follows the bit one clock later.
   always @(posedge i_clk) begin
      if (!i_nrst) begin
         o_irq_pin_a <= 1'b0;
         o_irq_pin_b <= 1'b0;
      end else begin
         o_irq_pin_a <= (|(live & ~interrupt_pin_routing_ff)) ^ inv;
         o_irq_pin_b <= (|(live & interrupt_pin_routing_ff)) ^ inv;
      end // [R12] [R13] [R18]
   end

   // ****************************************************************
   // Detector chaining and automatic sleep.
   // ****************************************************************
   // Inactivity is watched first; activity only after it has fired.
   always @* begin
      nxt_phase = phase_ff;
      if (!chain_on || !meas) begin
         nxt_phase = S_WAIT_INACT;
      end else begin
         case (phase_ff)
            S_WAIT_INACT:
               if (i_evt[`PIFC_EV_INACT])
                  nxt_phase = S_WAIT_ACT; // [R01]
            S_WAIT_ACT:
               if (i_evt[`PIFC_EV_ACT])
                  nxt_phase = S_WAIT_INACT; // [R01]
            default:
               nxt_phase = S_WAIT_INACT;
         endcase
      end
   end

   // Sleep on inactivity, wake on activity only if activity is on.
   always @* begin
      nxt_auto_sleep = auto_sleep_ff;
      if (!auto_ok || !meas)
         nxt_auto_sleep = 1'b0; // [R03]
      else if (i_inact_on && i_evt[`PIFC_EV_INACT])
         nxt_auto_sleep = 1'b1; // [R02]
      else if (i_act_on && i_evt[`PIFC_EV_ACT])
         nxt_auto_sleep = 1'b0; // [R02]
   end

   always @(posedge i_clk) begin
      if (!i_nrst) begin
         phase_ff      <= S_WAIT_INACT;
         auto_sleep_ff <= 1'b0;
      end else begin
         phase_ff      <= nxt_phase;
         auto_sleep_ff <= nxt_auto_sleep;
      end
   end

   // ****************************************************************
   // Sampling clock and sleep rate divider.
   // ****************************************************************
   // The rate pin comes from another domain; the third stage only
   // remembers the previous synchronised level for edge detection.
   always @(posedge i_clk) begin
      if (!i_nrst)
         odr_sync_ff <= 3'h0;
      else
         odr_sync_ff <= {odr_sync_ff[1:0], i_odr_clk};
   end

   // The divider period doubles per field step: 8, 4, 2 or 1 Hz.
   always @* begin
      nxt_sleep_cnt = sleep_cnt_ff + 32'h1;
      nxt_tick      = 1'b0;
      if (!sleeping || !meas) begin
         nxt_sleep_cnt = 32'h0;
         nxt_tick      = meas & odr_edge;
      end else if (sleep_cnt_ff >=
                   (P_SLEEP_CYC << rate) - 32'h1) begin // [R08]
         nxt_sleep_cnt = 32'h0;
         nxt_tick      = 1'b1; // [R06]
      end
   end

   always @(posedge i_clk) begin
      if (!i_nrst) begin
         sleep_cnt_ff  <= 32'h0;
         o_sample_tick <= 1'b0;
      end else begin
         sleep_cnt_ff  <= nxt_sleep_cnt;
         o_sample_tick <= nxt_tick;
      end
   end

   // ****************************************************************
   // Power state outputs.
   // ****************************************************************
   // Sleep keeps only the activity detector alive.
   always @(posedge i_clk) begin
      if (!i_nrst) begin
         o_measure    <= 1'b0;
         o_asleep     <= 1'b0;
         o_fifo_wr_en <= 1'b0;
         o_act_run    <= 1'b0;
         o_inact_run  <= 1'b0;
         o_other_run  <= 1'b0;
      end else begin
         o_measure    <= meas; // [R05]
         o_asleep     <= meas & sleeping;
         o_fifo_wr_en <= meas & ~sleeping; // [R06]
         o_act_run    <= meas & i_act_on &
                         (~chain_on | phase_ff[1]); // [R01] [R07]
         o_inact_run  <= meas & i_inact_on & ~sleeping &
                         (~chain_on | phase_ff[0]); // [R01] [R07]
         o_other_run  <= meas & ~sleeping; // [R07]
      end
   end

   // ****************************************************************
   // Sensor and serial port mode outputs.
   // ****************************************************************
   always @(posedge i_clk) begin
      if (!i_nrst) begin
         o_self_test <= 1'b0;
         o_spi3      <= 1'b0;
      end else begin
         o_self_test <= output_format_control_ff[`PIFC_FMT_STEST]; // [R16]
         o_spi3      <= output_format_control_ff[`PIFC_FMT_SPI3]; // [R17]
      end
   end

   // ****************************************************************
   // Output data, updated on every sample tick, asleep or not.
   // ****************************************************************
   // Format changes take effect at the next tick, so a sample set is
   // never mixed between two formats.
   genvar ax;
   generate
      for (ax = 0; ax < 3; ax = ax + 1) begin : g_axis
         always @(posedge i_clk) begin
            if (!i_nrst)
               o_data[16*ax+15:16*ax] <= 16'h0000;
            else if (nxt_tick)
               o_data[16*ax+15:16*ax] <=
                  fmt(i_raw[P_RAW_W*ax+P_RAW_W-1:P_RAW_W*ax],
                      rng, full, just); // [R07]
         end
      end
   endgenerate

endmodule // pifc_regs

`default_nettype wire

// >>> test/pifc_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Port checker of the control bank.
// ****************************************************************
module pifc_checker #(
   parameter P_SLEEP_CYC = 16,
   parameter P_RAW_W     = 13
) (
   input wire logic       i_clk,
   input wire logic       i_nrst,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic       i_wr,
   input wire logic [7:0] i_evt,
   input wire logic       o_irq_pin_a,
   input wire logic       o_irq_pin_b,
   input wire logic       o_measure,
   input wire logic       o_asleep,
   input wire logic       o_sample_tick,
   input wire logic       o_fifo_wr_en,
   input wire logic       o_inact_run,
   input wire logic       o_other_run,
   input wire logic       o_self_test,
   input wire logic       o_spi3
);
   logic [7:0] pw_ff, en_ff, rt_ff, fm_ff;

   // Shadows of the writable fields, so pins can be tied to their cause.
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         pw_ff <= 8'h00;
         en_ff <= 8'h00;
         rt_ff <= 8'h00;
         fm_ff <= 8'h00;
      end else if (i_wr) begin
         case (i_addr)
            8'h2D: pw_ff <= i_wdata & 8'h3F;
            8'h2E: en_ff <= i_wdata;
            8'h2F: rt_ff <= i_wdata;
            8'h31: fm_ff <= i_wdata & 8'hEF;
            default: ;
         endcase
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);

   // Reset must leave the part in standby with idle pins.
   standby_reset_a: assert property (
      disable iff (1'b0) !i_nrst |=> !o_measure && !o_irq_pin_a
      && !o_irq_pin_b) else $error("outputs not idle after reset");
   measure_bit_a: assert property (
      i_wr && i_addr == 8'h2D |-> ##2 o_measure == $past(i_wdata[3], 2))
      else $error("measure output does not follow its bit");
   self_test_a: assert property (
      i_wr && i_addr == 8'h31 |-> ##2 o_self_test == $past(i_wdata[7], 2))
      else $error("self-test output does not follow its bit");
   spi_mode_a: assert property (
      i_wr && i_addr == 8'h31 |-> ##2 o_spi3 == $past(i_wdata[6], 2))
      else $error("serial mode output does not follow its bit");
   // An enabled activity event reaches its routed pin two edges later.
   event_pin_a: assert property (
      i_evt[4] && pw_ff[3] && en_ff[4] && !fm_ff[5] && !i_wr ##1 !i_wr
      |-> ##1 (rt_ff[4] ? o_irq_pin_b : o_irq_pin_a))
      else $error("enabled event missing on its pin");
   masked_pin_a: assert property (
      en_ff == 8'h00 && $stable(en_ff) && $stable(fm_ff) && !i_wr
      |=> o_irq_pin_a == fm_ff[5] && o_irq_pin_b == fm_ff[5])
      else $error("pin active with all sources masked");
   sleep_fifo_a: assert property (
      o_asleep |-> !o_fifo_wr_en) else $error("fifo fed while asleep");
   sleep_only_act_a: assert property (
      o_asleep |-> !o_inact_run && !o_other_run)
      else $error("detector other than activity runs asleep");
   // The auto-sleep state drops one edge after the bits change, so the
   // fields must have stood for two edges before the pin is judged.
   chain_off_a: assert property (
      !pw_ff[5] && !pw_ff[2] && $stable(pw_ff) && pw_ff == $past(pw_ff, 2)
      |-> !o_asleep)
      else $error("asleep without chaining or sleep bit");

   // Main scenarios that the bench must reach.
   cover property (i_evt[4] && en_ff[4] ##2 o_irq_pin_b);
   cover property ($rose(o_asleep) && pw_ff[5]);
   cover property (o_sample_tick && o_asleep);
endmodule // pifc_checker

bind pifc_regs pifc_checker #(
   .P_SLEEP_CYC(P_SLEEP_CYC),
   .P_RAW_W    (P_RAW_W)
) u_chk (
   .i_clk, .i_nrst, .i_addr, .i_wdata, .i_wr, .i_evt, .o_irq_pin_a,
   .o_irq_pin_b, .o_measure, .o_asleep, .o_sample_tick, .o_fifo_wr_en,
   .o_inact_run, .o_other_run, .o_self_test, .o_spi3
);
`default_nettype wire

// >>> test/pifc_link.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Output-rate clock source of the sensing front end.
// ****************************************************************
module pifc_link (
   input  wire logic i_run,
   output var  logic o_odr_clk
);
   // Period 160 ns; it stands low while not running. The odd start
   // offset keeps its edges away from the system clock edges.
   initial begin
      o_odr_clk = 1'b0;
      #7;
      forever begin
         #80;
         o_odr_clk = i_run ? ~o_odr_clk : 1'b0;
      end
   end
endmodule // pifc_link
`default_nettype wire

// >>> test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Self-checking bench of the control bank.
// ****************************************************************
module testbench;
   localparam int SC = 16;
   logic        i_clk, i_nrst, i_wr, i_rd, i_act_on, i_inact_on, run;
   logic [7:0]  i_addr, i_wdata, i_evt, o_rdata, pw, en, rt, fm, flg;
   logic [38:0] i_raw;
   logic [47:0] o_data;
   logic        i_odr_clk, o_irq_pin_a, o_irq_pin_b, o_measure, o_asleep;
   logic        o_sample_tick, o_fifo_wr_en, o_act_run, o_inact_run;
   logic        o_other_run, o_self_test, o_spi3;
   logic [15:0] lf;
   logic [12:0] rw [3];
   int          fail_count, checks_done, slp, n;

   pifc_regs #(.P_SLEEP_CYC(SC), .P_RAW_W(13)) DUT (
      .i_clk, .i_nrst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
      .i_odr_clk, .i_act_on, .i_inact_on, .i_evt, .i_raw, .o_data,
      .o_irq_pin_a, .o_irq_pin_b, .o_measure, .o_asleep, .o_sample_tick,
      .o_fifo_wr_en, .o_act_run, .o_inact_run, .o_other_run,
      .o_self_test, .o_spi3);
   pifc_link u_link (.i_run(run), .o_odr_clk(i_odr_clk));

   always #10 i_clk = ~i_clk;

   // Shift register source of random values.
   function automatic logic [15:0] rnd(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // Expected register contents as software reads them.
   function automatic logic [7:0] mr(input logic [7:0] a);
      case (a)
         8'h2D: return pw;
         8'h2E: return en;
         8'h2F: return rt;
         8'h30: return flg;
         8'h31: return fm;
         default: return 8'h00;
      endcase
   endfunction
   // Expected output word: clip, scale, then justify.
   function automatic logic [15:0] fmt(input int v, r, f, j);
      int m;
      m = 512 << r;
      if (r != 3 && v >= m) v = m - 1;
      if (r != 3 && v < -m) v = -m;
      if (f == 0) v = v >>> r;
      if (j != 0) v = v << (16 - (f ? 10 + r : 10));
      return v[15:0];
   endfunction
   task automatic results;
      $display("Checks %0d, errors %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
      case (a)
         8'h2D: pw = d & 8'h3F;
         8'h2E: en = d;
         8'h2F: rt = d;
         8'h31: fm = d & 8'hEF;
         default: ;
      endcase
   endtask
   // A read also applies the clearing side effects to the model.
   task automatic rdc(input logic [7:0] a);
      logic [7:0] e;
      e = mr(a);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1;
      chk(o_rdata, e);
      if (a == 8'h30) flg &= 8'h83;
      if (a >= 8'h32 && a <= 8'h37) flg &= 8'h7C;
   endtask
   // One event pulse; standby drops all, sleep drops data-ready.
   task automatic ev(input int b);
      @(posedge i_clk);
      i_evt <= 8'h01 << b;
      @(posedge i_clk);
      i_evt <= 8'h00;
      if (pw[3] && !(b == 7 && slp != 0)) flg |= 8'h01 << b;
   endtask
   task automatic pins;
      repeat (2) @(posedge i_clk);
      #1;
      chk({o_irq_pin_a, o_irq_pin_b},
          {|(flg & en & ~rt) ^ fm[5], |(flg & en & rt) ^ fm[5]});
   endtask
   task automatic wait_cyc(input int c);
      repeat (c) @(posedge i_clk);
      #1;
   endtask
   task automatic tick;
      n = 0;
      do begin
         @(posedge i_clk);
         #1;
         n++;
      end while (o_sample_tick !== 1'b1 && n < 3000);
      if (n >= 3000) begin
         fail_count++;
         $display("Error at %0t: no sample tick", $time);
         results;
      end
   endtask

   // ****************************************************************
   // Main sequence.
   // ****************************************************************
   initial begin
      i_clk = 0; i_nrst = 0; i_wr = 0; i_rd = 0; i_addr = 0; i_wdata = 0;
      i_evt = 0; i_raw = 0; i_act_on = 0; i_inact_on = 0; run = 0;
      pw = 0; en = 0; rt = 0; fm = 0; flg = 0; slp = 0;
      fail_count = 0; checks_done = 0; lf = 16'h002A;
      repeat (3) @(posedge i_clk);
      i_nrst <= 1'b1;
      for (int i = 0; i < 6; i++) rdc(8'h2D + 8'(i));
      // Random register traffic, read-only and unmapped places included.
      for (int i = 0; i < 12; i++) begin
         lf = rnd(lf);
         wr(8'h2D + 8'(i % 6), lf[7:0]);
         rdc(8'h2D + 8'(i % 6));
      end
      wait_cyc(2);
      chk({o_measure, o_self_test, o_spi3}, {pw[3], fm[7:6]});
      chk({o_asleep, o_fifo_wr_en}, {pw[3] & pw[2], pw[3] & !pw[2]});
      // Go through standby first, configure, then enable outputs.
      wr(8'h2D, 8'h00);
      wr(8'h31, 8'h00);
      lf = rnd(lf);
      wr(8'h2F, lf[7:0]);
      wr(8'h2D, 8'h08);
      wr(8'h2E, 8'hFF);
      for (int b = 0; b < 8; b++) begin
         ev(b);
         pins;
      end
      rdc(8'h30);
      pins;
      rdc(8'h32);
      rdc(8'h30);
      wr(8'h31, 8'h20);
      pins;
      wr(8'h2E, 8'h00);
      for (int b = 0; b < 8; b++) ev(b);
      pins;
      rdc(8'h30);
      rdc(8'h33);
      wr(8'h2D, 8'h00);
      ev(4);
      rdc(8'h30);
      // Sample path: every range, width and justification.
      run = 1;
      wr(8'h2D, 8'h08);
      for (int k = 0; k < 16; k++) begin
         for (int a = 0; a < 3; a++) begin
            lf = rnd(lf);
            rw[a] = lf[12:0];
         end
         @(posedge i_clk);
         i_raw <= {rw[2], rw[1], rw[0]};
         wr(8'h31, {4'h0, k[3:0]});
         tick;
         tick;
         for (int a = 0; a < 3; a++)
            chk(o_data[16*a +: 16], fmt($signed(rw[a]), k % 4, k / 8, (k / 4) % 2));
      end
      // Manual sleep at each reading rate.
      for (int r = 0; r < 4; r++) begin
         wr(8'h2D, 8'h0C | 8'(r));
         wait_cyc(140);
         n = 0;
         repeat (512) begin
            @(posedge i_clk);
            #1;
            n += o_sample_tick;
         end
         chk(n >= (32 >> r) - 1 && n <= (32 >> r) + 1, 1);
         chk({o_asleep, o_fifo_wr_en}, 2'b10);
      end
      slp = 1;
      ev(7);
      ev(4);
      rdc(8'h30);
      wr(8'h2D, 8'h00);
      slp = 0;
      run = 0;
      // Chained detectors with automatic sleep, then without chaining.
      i_act_on <= 1'b1;
      i_inact_on <= 1'b1;
      wr(8'h2D, 8'h38);
      wait_cyc(3);
      chk({o_act_run, o_inact_run}, 2'b01);
      ev(3);
      wait_cyc(3);
      chk({o_asleep, o_act_run, o_inact_run}, 3'b110);
      ev(4);
      wait_cyc(3);
      chk({o_asleep, o_act_run, o_inact_run}, 3'b001);
      wr(8'h2D, 8'h00);
      wr(8'h2D, 8'h18);
      ev(3);
      wait_cyc(3);
      chk({o_asleep, o_act_run, o_inact_run}, 3'b011);
      results;
   end
endmodule // testbench
`default_nettype wire
